// >>> rtl/eec_bank.sv
// Error event counter bank with byte-wide clear-on-read access
`timescale 1ns/10ps
module eec_bank (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire eec_pkg::eec_fmt_e        framing_mode,
  input  wire eec_pkg::eec_evt_s        events,
  input  wire eec_pkg::eec_rd_s         rd_req,
  output logic [eec_pkg::EEC_DW-1:0]    rd_data_r,
  output logic                          rd_valid_r
);
  import eec_pkg::*;

  // Byte lanes of one count and the slot of each counter in the bank
  localparam int HI_LSB  = EEC_CW - EEC_DW;
  localparam int IDX_LCV = 0;
  localparam int IDX_FRM = 1;
  localparam int IDX_PAR = 2;
  localparam int IDX_FEB = 3;
  localparam int IDX_CBT = 4;
  localparam int NBYTES  = EEC_A_LAST - EEC_A_BASE + 1;

  logic [EEC_NCNT-1:0]           evt_vec;
  logic [EEC_NCNT-1:0]           clr_vec;
  logic [EEC_NCNT-1:0]           hi_sel;
  logic [EEC_NCNT-1:0]           lo_sel;
  logic [EEC_CW-1:0]             cnt    [EEC_NCNT];
  logic [EEC_DW-1:0]             cnt_hi [EEC_NCNT];
  logic [EEC_DW-1:0]             cnt_lo [EEC_NCNT];
  logic [EEC_DW-1:0]             hold_r;
  logic [EEC_DW-1:0]             hold_nxt;
  logic [EEC_DW-1:0]             data_nxt;
  logic                          rd_valid_nxt;
  logic                          hold_sel;
  logic                          parity_evt;
  logic                          cbit_mode;

  // Map and counter array must agree, else a pair would decode to no counter
  if (2 * EEC_DW != EEC_CW) begin : g_chk_width
    $error("eec_bank: a count must split into exactly two bytes");
  end
  if (NBYTES != 2 * EEC_NCNT) begin : g_chk_pairs
    $error("eec_bank: pair range does not match the number of counters");
  end
  if (EEC_A_BASE[0] != 1'b0) begin : g_chk_align
    $error("eec_bank: the pair range must start on an even address");
  end
  if (EEC_A_HOLD >= EEC_A_BASE && EEC_A_HOLD <= EEC_A_LAST) begin : g_chk_hold
    $error("eec_bank: holding register overlaps a counter pair");
  end

  // Upper byte of counter i sits at the even address of its pair
  function automatic logic [EEC_AW-1:0] hi_addr(input int i);
    return EEC_A_BASE + EEC_AW'(2 * i);
  endfunction : hi_addr

  function automatic logic [EEC_AW-1:0] lo_addr(input int i);
    return hi_addr(i) + EEC_AW'(1);
  endfunction : lo_addr

  function automatic logic [EEC_DW-1:0] hi_byte(input logic [EEC_CW-1:0] c);
    return c[EEC_CW-1:HI_LSB];
  endfunction : hi_byte

  function automatic logic [EEC_DW-1:0] lo_byte(input logic [EEC_CW-1:0] c);
    return c[EEC_DW-1:0];
  endfunction : lo_byte

  // Parity source follows the framing format
  always_comb begin
    case (framing_mode)
      EEC_FMT_DS3_CBIT: parity_evt = events.p_bit_error;
      EEC_FMT_DS3_M13:  parity_evt = events.p_bit_error;
      EEC_FMT_E3_G751:  parity_evt = events.bip4_error;
      EEC_FMT_E3_G832:  parity_evt = events.bip8_error;
      default:          parity_evt = 1'b0;
    endcase
  end

  // C-bit parity only exists in C-bit framing; other modes must not count it
  always_comb begin
    case (framing_mode)
      EEC_FMT_DS3_CBIT: cbit_mode = 1'b1;
      default:          cbit_mode = 1'b0;
    endcase
  end

  assign evt_vec[IDX_LCV] = events.line_code_violation;
  assign evt_vec[IDX_FRM] = events.framing_error;
  assign evt_vec[IDX_PAR] = parity_evt;
  assign evt_vec[IDX_FEB] = events.far_end_block_error;
  assign evt_vec[IDX_CBT] = events.cbit_error && cbit_mode;

  genvar gi;
  generate
    for (gi = 0; gi < EEC_NCNT; gi++) begin : g_cnt
      assign hi_sel[gi]  = rd_req.rd && (rd_req.addr == hi_addr(gi));
      assign lo_sel[gi]  = rd_req.rd && (rd_req.addr == lo_addr(gi));
      // Either byte counts as the first read, so either one clears the count
      assign clr_vec[gi] = hi_sel[gi] || lo_sel[gi];
      assign cnt_hi[gi]  = hi_byte(cnt[gi]);
      assign cnt_lo[gi]  = lo_byte(cnt[gi]);
      eec_counter #(
        .CW (EEC_CW)
      ) u_cnt (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .evt     (evt_vec[gi]),
        .clr     (clr_vec[gi]),
        .cnt_r   (cnt[gi])
      );
    end
  endgenerate

  assign hold_sel = rd_req.rd && (rd_req.addr == EEC_A_HOLD);

  // Unmapped addresses fall through to zero; the read is still answered
  always_comb begin
    data_nxt = EEC_BYTE_RST;
    for (int i = 0; i < EEC_NCNT; i++) begin
      if (hi_sel[i]) begin
        data_nxt = cnt_hi[i];
      end
      if (lo_sel[i]) begin
        data_nxt = cnt_lo[i];
      end
    end
    if (hold_sel) begin
      data_nxt = hold_r;
    end
  end

  // Holding takes the pre-clear byte; a later pair read overwrites it
  always_comb begin
    hold_nxt = hold_r;
    for (int i = 0; i < EEC_NCNT; i++) begin
      if (hi_sel[i]) begin
        hold_nxt = cnt_lo[i];
      end
      if (lo_sel[i]) begin
        hold_nxt = cnt_hi[i];
      end
    end
    if (hold_sel) begin
      hold_nxt = EEC_BYTE_RST;
    end
  end

  assign rd_valid_nxt = rd_req.rd;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_r <= EEC_BYTE_RST;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= EEC_BYTE_RST;
    end else begin
      rd_data_r <= data_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
    end
  end
endmodule : eec_bank

// >>> include/eec_pkg.sv
// Package for the error event counter bank: map, widths, framing modes
package eec_pkg;
  localparam int          EEC_AW       = 8;
  localparam int          EEC_DW       = 8;
  localparam int          EEC_CW       = 16;
  localparam int          EEC_NCNT     = 5;
  localparam logic [7:0]  EEC_A_LCV_HI = 8'h50;
  localparam logic [7:0]  EEC_A_LCV_LO = 8'h51;
  localparam logic [7:0]  EEC_A_FRM_HI = 8'h52;
  localparam logic [7:0]  EEC_A_FRM_LO = 8'h53;
  localparam logic [7:0]  EEC_A_PAR_HI = 8'h54;
  localparam logic [7:0]  EEC_A_PAR_LO = 8'h55;
  localparam logic [7:0]  EEC_A_FEB_HI = 8'h56;
  localparam logic [7:0]  EEC_A_FEB_LO = 8'h57;
  localparam logic [7:0]  EEC_A_CBT_HI = 8'h58;
  localparam logic [7:0]  EEC_A_CBT_LO = 8'h59;
  localparam logic [7:0]  EEC_A_HOLD   = 8'h6c;
  localparam logic [7:0]  EEC_A_BASE   = 8'h50;
  localparam logic [7:0]  EEC_A_LAST   = 8'h59;
  localparam logic [15:0] EEC_CNT_RST  = 16'h0000;
  localparam logic [15:0] EEC_CNT_ONE  = 16'h0001;
  localparam logic [15:0] EEC_CNT_MAX  = 16'hffff;
  localparam logic [7:0]  EEC_BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    EEC_FMT_DS3_CBIT = 2'b00,
    EEC_FMT_DS3_M13  = 2'b01,
    EEC_FMT_E3_G751  = 2'b10,
    EEC_FMT_E3_G832  = 2'b11
  } eec_fmt_e;

  typedef struct packed {
    logic line_code_violation;
    logic framing_error;
    logic p_bit_error;
    logic bip4_error;
    logic bip8_error;
    logic far_end_block_error;
    logic cbit_error;
  } eec_evt_s;

  typedef struct packed {
    logic             rd;
    logic [EEC_AW-1:0] addr;
  } eec_rd_s;
endpackage : eec_pkg

// >>> rtl/eec_counter.sv
// One saturating clear-on-read 16-bit event counter
`timescale 1ns/10ps
module eec_counter #(
  parameter int CW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          evt,
  input  wire logic          clr,
  output logic [CW-1:0]      cnt_r
);
  import eec_pkg::*;
  logic [CW-1:0] cnt_nxt;

  // The clear and saturation constants are 16 bits wide
  if (CW != EEC_CW) begin : g_chk_width
    $error("eec_counter: only 16-bit counters are supported");
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = evt ? EEC_CNT_ONE : EEC_CNT_RST;
    end else if (evt && cnt_r != EEC_CNT_MAX) begin
      cnt_nxt = cnt_r + EEC_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= EEC_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : eec_counter

// >>> testbench/eec_bank_asserts.sv
// Port checker for the error event counter bank
`timescale 1ns/10ps
module eec_bank_asserts (
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire eec_pkg::eec_fmt_e framing_mode,
  input wire eec_pkg::eec_evt_s events,
  input wire eec_pkg::eec_rd_s  rd_req,
  input wire logic [7:0]        rd_data_r,
  input wire logic              rd_valid_r
);
  import eec_pkg::*;
  wire       r = rd_req.rd;
  wire [7:0] a = rd_req.addr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_vld; r |=> rd_valid_r; endproperty
  a_vld: assert property (p_vld) else $error("read not answered");
  property p_idle; !r |=> !rd_valid_r && rd_data_r == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  property p_map; r && !(a inside {[8'h50:8'h59], 8'h6c}) |=> rd_data_r == 8'h00; endproperty
  a_map: assert property (p_map) else $error("unmapped read not zero");
  property p_hold; r && a == 8'h6c ##1 r && a == 8'h6c |=> rd_data_r == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("holding byte not cleared");
  property p_clr;
    r && a == 8'h51 && !events.line_code_violation ##1 r && a == 8'h51 |=> rd_data_r == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("counter not cleared");
  property p_set; r && a == 8'h53 && events.framing_error ##1 r && a == 8'h53 |=> rd_data_r == 8'h01;
  endproperty
  a_set: assert property (p_set) else $error("event lost at clear");
  property p_cbt;
    r && a == 8'h59 && framing_mode != EEC_FMT_DS3_CBIT ##1 r && a == 8'h59 |=> rd_data_r == 8'h00;
  endproperty
  a_cbt: assert property (p_cbt) else $error("c-bit counter active");
  property p_bip8;
    r && a == 8'h55 && framing_mode == EEC_FMT_E3_G832 && events.bip8_error
      ##1 r && a == 8'h55 |=> rd_data_r == 8'h01;
  endproperty
  a_bip8: assert property (p_bip8) else $error("bip-8 not counted");
endmodule : eec_bank_asserts

// >>> testbench/eec_host.sv
// Microprocessor model issuing byte reads
`timescale 1ns/10ps
module eec_host (
  input wire logic         sys_clk,
  output eec_pkg::eec_rd_s rd_req,
  input wire logic [7:0]   rd_data_r
);
  import eec_pkg::*;
  initial rd_req = '0;
  // Request held over one edge; back-to-back calls keep the bus busy
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    rd_req = '{rd: 1'b1, addr: a};
    @(negedge sys_clk);
    d = rd_data_r;
  endtask : rd
  task automatic idle();
    rd_req = '0;
  endtask : idle
endmodule : eec_host

// >>> testbench/eec_bank_test.sv
// Self-checking bench for the error event counter bank
`timescale 1ns/10ps
module eec_bank_test;
  import eec_pkg::*;
  logic sys_clk, rstn, rd_valid_r;
  eec_fmt_e framing_mode;
  eec_evt_s events;
  eec_rd_s rd_req;
  logic [7:0] rd_data_r, d;
  logic [15:0] cnt [5];
  logic [7:0] ta [12] = '{8'h6c, 8'h6c, 8'h5a, 8'h55, 8'h55, 8'h53,
                          8'h59, 8'h59, 8'h53, 8'h53, 8'h51, 8'h51};
  int num_errors = 0, checks = 0, cyc = 0;
  eec_bank DUT (.sys_clk(sys_clk), .rstn(rstn), .framing_mode(framing_mode),
    .events(events), .rd_req(rd_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
  eec_host host (.sys_clk(sys_clk), .rd_req(rd_req), .rd_data_r(rd_data_r));
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic hit(int i, eec_evt_s e, eec_fmt_e m);
    case (i)
      0: return e.line_code_violation;
      1: return e.framing_error;
      2: return m[1] ? (m[0] ? e.bip8_error : e.bip4_error) : e.p_bit_error;
      3: return e.far_end_block_error;
      default: return e.cbit_error && m == EEC_FMT_DS3_CBIT;
    endcase
  endfunction : hit
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Model saturates, so a long burst must read back all ones
  task automatic run(int n, logic [6:0] m, logic [6:0] f);
    repeat (n) begin
      events = eec_evt_s'(7'(($urandom & m) | f));
      for (int i = 0; i < 5; i++)
        if (hit(i, events, framing_mode) && cnt[i] != 16'hffff) cnt[i]++;
      @(negedge sys_clk);
    end
    events = '0;
  endtask : run
  task automatic drain(bit lo);
    for (int i = 0; i < 5; i++) begin
      host.rd(8'h50 + 8'(2 * i) + 8'(lo), d);
      chk("first byte", lo ? cnt[i][7:0] : cnt[i][15:8], d);
      host.rd(8'h6c, d);
      chk("held byte", lo ? cnt[i][15:8] : cnt[i][7:0], d);
      cnt[i] = '0;
    end
    host.idle();
  endtask : drain
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    rstn = 0;
    events = '0;
    framing_mode = EEC_FMT_DS3_CBIT;
    foreach (cnt[i]) cnt[i] = '0;
    void'($urandom(44));
    repeat (5) @(negedge sys_clk);
    rstn = 1;
    drain(0);
    for (int m = 0; m < 4; m++) begin
      framing_mode = eec_fmt_e'(m);
      run(600, 7'h7f, 7'h00);
      drain(m[0]);
    end
    // Mid-run reset must clear counts and the holding byte
    run(40, 7'h7f, 7'h00);
    host.rd(8'h50, d);
    chk("first byte", cnt[0][15:8], d);
    host.idle();
    rstn = 0;
    foreach (cnt[i]) cnt[i] = '0;
    repeat (2) @(negedge sys_clk);
    rstn = 1;
    host.rd(8'h6c, d);
    chk("held byte", 8'h00, d);
    drain(1);
    @(negedge sys_clk);
    for (int k = 0; k < 12; k++) begin
      events = eec_evt_s'(k == 3 ? 7'h25 : k == 8 ? 7'h20 : 7'h00);
      host.rd(ta[k], d);
      chk("corner read", 8'(12'h230 >> k & 12'h001), d);
    end
    events = '0;
    host.idle();
    run(65600, 7'h00, 7'h40);
    drain(0);
    print_verdict();
  end
endmodule : eec_bank_test
bind eec_bank eec_bank_asserts chk_u (.sys_clk(sys_clk), .rstn(rstn),
  .framing_mode(framing_mode), .events(events), .rd_req(rd_req),
  .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
